/* hw/sfs_pkg.sv */
/*
 * Constants, field layouts and carrier types of the frame status queue.
 * Assumes byte addressing on the register bus, one register per word.
 */
// What this block does
// - closing flag pushes count and five status bits
// - frame end resets the receive CRC checker
// - queue holds ten frames; eleventh is overrun
// - aborted frame still stored, counter then cleared
// - queue works only when enabled in SDLC
// - pointers cleared when disabled or reset
// - reset clears the queue enable bit
// - disabled queue: locations four-seven mirror zero-three
// - feature status bit 2 shows queue enabled
// - status and count reads return head entry
// - empty queue switches status to live source
// - data-available bit set while queue not empty
// - of the status bits, only residue, overrun, CRC error are queued
// - end-of-frame reads one when status queued
// - count high read latches not-empty, arms the status pop
// - one pop per entry, never underflow
// - frame end advances write pointer after load
// - overflow flag cleared only by reset or queue disable
// - anti-lock mode: no lock on end of frame, data vector interrupt
// - overrun or parity: special interrupt, buffer locked
// - queue ten deep, nineteen bits wide
// - byte counter counts characters, cleared on flag
package sfs_pkg;
	localparam int CNT_W   = 14;
	localparam int Q_DEPTH = 10;
	localparam int ADDR_W  = 8;

	localparam logic [7:0] OFS_MAIN      = 8'h00;
	localparam logic [7:0] OFS_SPEC      = 8'h04;
	localparam logic [7:0] OFS_VEC       = 8'h08;
	localparam logic [7:0] OFS_PEND      = 8'h0c;
	localparam logic [7:0] OFS_MAIN_IMG  = 8'h10;
	localparam logic [7:0] OFS_SPEC_IMG  = 8'h14;
	localparam logic [7:0] OFS_CNT_LOW   = 8'h18;
	localparam logic [7:0] OFS_CNT_HIGH  = 8'h1c;
	localparam logic [7:0] OFS_DATA      = 8'h20;
	localparam logic [7:0] OFS_EXT       = 8'h3c;
	localparam logic [7:0] OFS_CMD       = 8'h40;

	localparam int QEN_BIT      = 2;
	localparam int OVF_BIT      = 7;
	localparam int AVAIL_BIT    = 6;
	localparam int SPC_ONLY_HI  = 4;
	localparam int SPC_ONLY_LO  = 3;
	localparam int CMD_ERR_RST  = 0;
	localparam int CMD_CLR_TOP  = 1;

	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] IRQM_RST = 8'h00;

	typedef struct packed {
		logic       crc_err;
		logic       overrun;
		logic [2:0] residue;
	} sfs_stat_t;

	typedef struct packed {
		sfs_stat_t        stat;
		logic [CNT_W-1:0] count;
	} sfs_entry_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} sfs_av_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} sfs_av_rsp_t;

	typedef struct packed {
		logic       char_valid;
		logic       flag;
		logic       frame_end;
		logic       abort;
		logic       sdlc_mode;
		logic       eof;
		logic       crc_err;
		logic       overrun;
		logic       parity;
		logic [2:0] residue;
		logic       all_sent;
	} sfs_rx_t;
endpackage

/* hw/sfs_queue.sv */
/*
 * Flip-flop status queue with head/tail pointers and sticky overflow.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sfs_queue #(
	parameter int DEPTH = sfs_pkg::Q_DEPTH
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               clr,
	input  wire logic               push,
	input  wire logic               pop,
	input  wire sfs_pkg::sfs_entry_t wr_data,
	output sfs_pkg::sfs_entry_t     head,
	output logic                    empty,
	output logic                    full,
	output logic                    overflow
);
	import sfs_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	sfs_entry_t    mem [DEPTH];
	logic [PW-1:0] head_reg;
	logic [PW-1:0] tail_reg;
	logic [CW-1:0] fill_reg;
	logic          ovf_reg;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	wire do_push = push & ~full;
	wire do_pop  = pop & ~empty;

	assign empty    = (fill_reg == '0);
	assign full     = (fill_reg == CW'(DEPTH));
	assign head     = mem[head_reg];
	assign overflow = ovf_reg;

	always_ff @(posedge clk) begin
		if (do_push)
			mem[tail_reg] <= wr_data;
	end

	always_ff @(posedge clk) begin
		if (rst || clr) begin
			head_reg <= '0;
			tail_reg <= '0;
			fill_reg <= '0;
			ovf_reg  <= 1'b0;
		end else begin
			if (do_push)
				tail_reg <= step(tail_reg);
			if (do_pop)
				head_reg <= step(head_reg);
			if (do_push != do_pop)
				fill_reg <= do_push ? fill_reg + 1'b1 : fill_reg - 1'b1;
			if (push && full)
				ovf_reg <= 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	fill_bound_a: assert property (fill_reg <= CW'(DEPTH))
		else $error("queue holds more than its depth");
	ovf_sticky_a: assert property (overflow && !clr |=> overflow)
		else $error("overflow flag dropped without disable");
	no_under_a: assert property (pop && empty && !push && !clr
		|=> empty)
		else $error("pop on empty queue changed fill");
	ovf_cause_a: assert property (push && full && !pop && !clr
		|=> overflow && full)
		else $error("push into full queue not flagged");
endmodule
`default_nettype wire

/* hw/sfs_top.sv */
/*
 * Frame status queue of an SDLC receiver channel with its register view.
 * Assumes an Avalon-MM master on clk, a receiver and receive data
 * buffer on the same clock, and an interrupt block that takes the
 * request levels.
 */
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sfs_top #(
	parameter int DEPTH = sfs_pkg::Q_DEPTH
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire sfs_pkg::sfs_av_req_t av_req,
	output sfs_pkg::sfs_av_rsp_t     av_rsp,
	input  wire sfs_pkg::sfs_rx_t     rx,
	input  wire logic [7:0]          main_status,
	input  wire logic [7:0]          vec_status,
	input  wire logic [7:0]          pend_status,
	input  wire logic [7:0]          rx_top_data,
	input  wire logic                rx_top_valid,
	input  wire logic                rx_top_eof,
	input  wire logic                rx_top_err,
	output logic                     rx_data_pop,
	output logic                     crc_reset,
	output logic                     rx_lock,
	output logic                     rxdata_irq,
	output logic                     special_irq
);
	import sfs_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// bus handshake: one wait cycle, effects at accept
	logic        ack_reg;
	logic [31:0] rdata_reg;

	wire req     = av_req.read | av_req.write;
	wire accept  = req & ack_reg;
	wire rd_acc  = accept & av_req.read;
	wire wr_acc  = accept & av_req.write & av_req.byteenable[0];
	wire rd_head = av_req.read & ~ack_reg;
	wire [ADDR_W-1:0] adr = av_req.address;
	wire [7:0] wbyte = av_req.writedata[7:0];

	assign av_rsp.waitrequest = req & ~ack_reg;
	assign av_rsp.readdata    = rdata_reg;

	always_ff @(posedge clk) begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// control registers
	logic [7:0] ctrl_reg;
	logic [7:0] irq_mode_reg;

	wire wr_ctrl = wr_acc & hit(adr, OFS_EXT);
	wire wr_irqm = wr_acc & hit(adr, OFS_SPEC);
	wire wr_cmd  = wr_acc & hit(adr, OFS_CMD);
	wire err_rst = wr_cmd & wbyte[CMD_ERR_RST];
	wire clr_top = wr_cmd & wbyte[CMD_CLR_TOP];

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= CTRL_RST;
			irq_mode_reg <= IRQM_RST;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= wbyte;
			if (wr_irqm)
				irq_mode_reg <= wbyte;
		end
	end

	wire q_on = ctrl_reg[QEN_BIT] & rx.sdlc_mode;

	// byte counter
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	wire frame_done = rx.frame_end | rx.abort;
	wire char_cnt   = rx.char_valid & rx.sdlc_mode;

	// a character in the capture cycle opens the next frame
	assign cnt_next = (frame_done || rx.flag) ?
		CNT_W'(char_cnt) :
		(char_cnt ? cnt_reg + 1'b1 : cnt_reg);

	always_ff @(posedge clk) begin
		if (rst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	// status queue
	sfs_entry_t entry;
	sfs_entry_t q_head;
	logic       q_empty;
	logic       q_full;
	logic       q_ovf;
	logic       q_pop;

	assign entry.stat.crc_err = rx.crc_err;
	assign entry.stat.overrun = rx.overrun;
	assign entry.stat.residue = rx.residue;
	assign entry.count        = cnt_reg;

	wire push = q_on & frame_done;

	sfs_queue #(
		.DEPTH(DEPTH)
	) u_queue (
		.clk      (clk),
		.rst      (rst),
		.clr      (~q_on),
		.push     (push),
		.pop      (q_pop),
		.wr_data  (entry),
		.head     (q_head),
		.empty    (q_empty),
		.full     (q_full),
		.overflow (q_ovf)
	);

	always_ff @(posedge clk) begin
		if (rst)
			crc_reset <= 1'b0;
		else
			crc_reset <= frame_done;
	end

	// steering latched by count-high read, one pop per latch
	logic steer_reg;

	wire rd_high = rd_acc & hit(adr, OFS_CNT_HIGH);
	wire rd_spec = rd_acc & hit(adr, OFS_SPEC);
	wire from_q  = q_on & ~q_empty;

	assign q_pop = rd_spec & steer_reg & from_q;

	always_ff @(posedge clk) begin
		if (rst || !q_on)
			steer_reg <= 1'b0;
		else if (rd_high)
			steer_reg <= from_q;
		else if (q_pop)
			steer_reg <= 1'b0;
	end

	// read views
	wire [7:0] spec_live = {rx.eof, rx.crc_err, rx.overrun,
		rx.parity, rx.residue, rx.all_sent};
	wire [7:0] spec_q = {1'b1, q_head.stat.crc_err,
		q_head.stat.overrun, rx.parity,
		q_head.stat.residue, rx.all_sent};
	wire [7:0] spec_view = from_q ? spec_q : spec_live;
	wire [7:0] cnt_low = from_q ? q_head.count[7:0] : 8'h00;
	wire [7:0] cnt_high = {q_ovf, ~q_empty,
		from_q ? q_head.count[CNT_W-1:8] : 6'h00};
	wire [7:0] reg6 = q_on ? cnt_low : vec_status;
	wire [7:0] reg7 = q_on ? cnt_high : pend_status;
	wire [7:0] ext_stat = 8'(q_on) << QEN_BIT;

	wire [7:0] rd_byte =
		(hit(adr, OFS_MAIN) || hit(adr, OFS_MAIN_IMG)) ? main_status :
		(hit(adr, OFS_SPEC) || hit(adr, OFS_SPEC_IMG)) ? spec_view :
		hit(adr, OFS_VEC)      ? vec_status :
		hit(adr, OFS_PEND)     ? pend_status :
		hit(adr, OFS_CNT_LOW)  ? reg6 :
		hit(adr, OFS_CNT_HIGH) ? reg7 :
		hit(adr, OFS_DATA)     ? rx_top_data :
		hit(adr, OFS_EXT)      ? ext_stat :
		8'h00;

	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= 32'h0000_0000;
		else if (rd_head)
			rdata_reg <= {24'h00_0000, rd_byte};
	end

	// receive data buffer handling
	logic lock_reg;
	logic rxd_irq_reg;
	logic spc_irq_reg;
	logic top_eof_reg;

	wire antilock = q_on & irq_mode_reg[SPC_ONLY_HI]
		& irq_mode_reg[SPC_ONLY_LO];
	wire data_rd = rd_acc & hit(adr, OFS_DATA)
		& rx_top_valid & ~lock_reg;
	wire top_eof = rx_top_valid & rx_top_eof;
	wire lock_set = data_rd
		& (rx_top_err | (rx_top_eof & ~antilock));
	wire rxd_set = antilock & top_eof & ~top_eof_reg;

	assign rx_data_pop = data_rd;
	assign rx_lock     = lock_reg;
	assign rxdata_irq  = rxd_irq_reg;
	assign special_irq = spc_irq_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			lock_reg    <= 1'b0;
			spc_irq_reg <= 1'b0;
			rxd_irq_reg <= 1'b0;
			top_eof_reg <= 1'b0;
		end else begin
			top_eof_reg <= top_eof;
			if (lock_set)
				lock_reg <= 1'b1;
			else if (err_rst)
				lock_reg <= 1'b0;
			if (lock_set)
				spc_irq_reg <= 1'b1;
			else if (err_rst)
				spc_irq_reg <= 1'b0;
			if (rxd_set)
				rxd_irq_reg <= 1'b1;
			else if (clr_top)
				rxd_irq_reg <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	crc_restart_a: assert property (frame_done |=> crc_reset)
		else $error("crc reset missing after frame end");
	cnt_restart_a: assert property (frame_done
		|=> cnt_reg == CNT_W'($past(char_cnt)))
		else $error("counter not restarted after capture");
	push_store_a: assert property (push && !q_full
		|=> !q_empty)
		else $error("frame end did not store an entry");
	disable_clr_a: assert property (!ctrl_reg[QEN_BIT]
		|=> q_empty && !q_ovf)
		else $error("queue not cleared while disabled");
	eof_forced_a: assert property (rd_head && hit(adr, OFS_SPEC)
		&& from_q |=> av_rsp.readdata[7])
		else $error("queued status read without eof");
	one_pop_a: assert property (q_pop
		|=> !steer_reg ##1 !q_pop)
		else $error("second pop without count high read");
	lock_hold_a: assert property (lock_reg && !err_rst
		|=> lock_reg)
		else $error("buffer lock released without error reset");
	antilock_a: assert property (antilock && data_rd
		&& rx_top_eof && !rx_top_err |=> !lock_reg)
		else $error("eof character locked buffer in anti-lock");
	avail_bit_a: assert property (rd_head && hit(adr, OFS_CNT_HIGH)
		&& q_on |=> av_rsp.readdata[AVAIL_BIT]
		== !$past(q_empty))
		else $error("data available bit wrong");
endmodule
`default_nettype wire

/* test/sfs_host.sv */
/* Host bus model: one register access at a time.
 * Assumes a slave on clk answering through waitrequest. */
`timescale 1ns/1ps
`default_nettype none
module sfs_host
	import sfs_pkg::*;
(
	input  wire logic                 clk,
	output sfs_pkg::sfs_av_req_t      req,
	input  wire sfs_pkg::sfs_av_rsp_t rsp
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output bit to);
		int n;
		n = 0;
		req <= '{!w, w, a, {24'h0, d}, 4'h1};
		do begin
			@(posedge clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 64);
		to = n >= 64;
		q = rsp.readdata[7:0];
		req <= '0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
/* Self-checking bench for the frame status queue.
 * Assumes sfs_host for bus cycles; receiver driven here. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sfs_pkg::*;
	logic        clk, rst;
	sfs_av_req_t req;
	sfs_av_rsp_t rsp;
	sfs_rx_t     rx;
	logic [7:0]  ms, vs, ps;
	logic        tv, te, ter, crc_r, lock, rdi, spi, pop_s;
	int          n_fail, checks;
	int          n_pop = 0;
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	sfs_host host (.clk(clk), .req(req), .rsp(rsp));
	sfs_top dut (
		.clk(clk), .rst(rst), .av_req(req), .av_rsp(rsp), .rx(rx),
		.main_status(ms), .vec_status(vs), .pend_status(ps),
		.rx_top_data(8'ha5), .rx_top_valid(tv), .rx_top_eof(te),
		.rx_top_err(ter), .rx_data_pop(pop_s), .crc_reset(crc_r),
		.rx_lock(lock), .rxdata_irq(rdi), .special_irq(spi));
	// counts accepted data buffer pops
	always @(posedge clk)
		if (pop_s === 1'b1)
			n_pop <= n_pop + 1;
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test;
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		bit to;
		host.xfer(w, a, d, q, to);
		if (to) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), q & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	// live status view: eof crc ovr parity residue all_sent
	function automatic logic [7:0] live();
		return {rx.eof, rx.crc_err, rx.overrun, rx.parity,
			rx.residue, rx.all_sent};
	endfunction
	function automatic logic [7:0] qs(input logic [4:0] st);
		return {1'b1, st[4:3], rx.parity, st[2:0], rx.all_sent};
	endfunction
	// n chars, then closing flag or abort; ovl adds a char on that edge
	task automatic frame(input int n, input logic ab,
		input logic [4:0] st, input logic ovl);
		repeat (n) begin
			rx.char_valid <= 1'b1;
			@(posedge clk);
		end
		{rx.crc_err, rx.overrun, rx.residue} <= st;
		rx.char_valid <= ovl;
		rx.frame_end <= !ab;
		rx.abort <= ab;
		@(posedge clk);
		rx.char_valid <= 1'b0;
		rx.frame_end <= 1'b0;
		rx.abort <= 1'b0;
		{rx.crc_err, rx.overrun, rx.residue} <= 5'h00;
		#1 chk("crc_reset", 8'(crc_r), 8'h01);
		@(posedge clk);
	endtask
	// count high, count low, then status, which pops
	task automatic pop_chk(input int n, input logic [4:0] st,
		input logic ov);
		rd(OFS_CNT_HIGH, {ov, 1'b1, n[13:8]});
		rd(OFS_CNT_LOW, n[7:0]);
		rd(OFS_SPEC, qs(st));
	endtask
	task automatic s_compat;
		rd(OFS_EXT, 8'h00, 8'h04);
		rd(OFS_MAIN_IMG, ms);
		rd(OFS_SPEC_IMG, live());
		rd(OFS_CNT_LOW, vs);
		rd(OFS_CNT_HIGH, ps);
		rx.sdlc_mode <= 1'b0;
		wr(OFS_EXT, 8'h04);
		frame(2, 1'b0, 5'h1f, 1'b0);
		rd(OFS_CNT_HIGH, ps);
		wr(OFS_EXT, 8'h00);
		rx.sdlc_mode <= 1'b1;
	endtask
	task automatic s_queue;
		wr(OFS_EXT, 8'h04);
		rd(OFS_EXT, 8'h04, 8'h04);
		rd(OFS_CNT_HIGH, 8'h00, 8'hc0);
		frame(5, 1'b0, 5'h15, 1'b1);
		frame(3, 1'b1, 5'h0a, 1'b0);
		rx.parity <= 1'b1;
		pop_chk(5, 5'h15, 1'b0);
		rd(OFS_SPEC, qs(5'h0a));
		pop_chk(4, 5'h0a, 1'b0);
		rd(OFS_CNT_HIGH, 8'h00, 8'hc0);
		rd(OFS_SPEC, live());
		rx.char_valid <= 1'b1;
		@(posedge clk);
		rx.char_valid <= 1'b0;
		rx.flag <= 1'b1;
		@(posedge clk);
		rx.flag <= 1'b0;
		frame(3, 1'b0, 5'h01, 1'b0);
		pop_chk(3, 5'h01, 1'b0);
		frame(2, 1'b0, 5'h03, 1'b0);
		wr(OFS_EXT, 8'h00);
		wr(OFS_EXT, 8'h04);
		rd(OFS_CNT_HIGH, 8'h00, 8'hc0);
	endtask
	task automatic s_ovf;
		repeat (11) frame(1, 1'b0, 5'h07, 1'b0);
		repeat (10) pop_chk(1, 5'h07, 1'b1);
		rd(OFS_CNT_HIGH, 8'h80, 8'hc0);
		wr(OFS_EXT, 8'h00);
		wr(OFS_EXT, 8'h04);
		rd(OFS_CNT_HIGH, 8'h00, 8'hc0);
	endtask
	task automatic s_lock;
		logic [7:0] q;
		wr(OFS_EXT, 8'h00);
		ter <= 1'b1;
		tv <= 1'b1;
		acc(1'b0, OFS_DATA, 8'h00, q);
		#1 chk("lock", 8'({lock, spi}), 8'h03);
		chk("data", q, 8'ha5);
		chk("pop", 8'(n_pop), 8'h01);
		@(posedge clk);
		acc(1'b0, OFS_DATA, 8'h00, q);
		chk("locked pop", 8'(n_pop), 8'h01);
		wr(OFS_CMD, 8'h01);
		ter <= 1'b0;
		#1 chk("unlock", 8'({lock, spi}), 8'h00);
		@(posedge clk);
		wr(OFS_EXT, 8'h04);
		wr(OFS_SPEC, 8'h18);
		te <= 1'b1;
		acc(1'b0, OFS_DATA, 8'h00, q);
		#1 chk("anti-lock", 8'({lock, rdi}), 8'h01);
		chk("anti-lock pop", 8'(n_pop), 8'h02);
		@(posedge clk);
		wr(OFS_CMD, 8'h02);
		#1 chk("clear top", 8'(rdi), 8'h00);
	endtask
	initial begin
		n_fail = 0;
		checks = 0;
		rst = 1'b1;
		rx = '0;
		rx.sdlc_mode = 1'b1;
		rx.all_sent = 1'b1;
		{ms, vs, ps} = 24'h5a3cc3;
		{tv, te, ter} = 3'b000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_compat();
		s_queue();
		s_ovf();
		s_lock();
		stop_test();
	end
endmodule
`default_nettype wire
